// File: hw/prac_pkg.sv
package prac_pkg;
  // ********************************************
  // register map (byte addresses)
  // ********************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SETPT = 8'h04;
  localparam logic [7:0] OFS_RAMP = 8'h08;
  localparam logic [7:0] OFS_KP = 8'h0c;
  localparam logic [7:0] OFS_KI = 8'h10;
  localparam logic [7:0] OFS_KD = 8'h14;
  localparam logic [7:0] OFS_FOLLOW_GAIN = 8'h18;
  localparam logic [7:0] OFS_ZERO = 8'h1c;
  localparam logic [7:0] OFS_ALARM = 8'h20;
  localparam logic [7:0] OFS_CAL_GAIN = 8'h24;
  localparam logic [7:0] OFS_CAL_OFS = 8'h28;
  localparam logic [7:0] OFS_COEF_A = 8'h2c;
  localparam logic [7:0] OFS_COEF_B = 8'h30;
  localparam logic [7:0] OFS_COEF_C = 8'h34;
  localparam logic [7:0] OFS_OUT_VAL = 8'h38;
  localparam logic [7:0] OFS_ERR = 8'h3c;
  localparam logic [7:0] OFS_RAMP_T = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h44;
  localparam logic [7:0] OFS_TMIN0 = 8'h80;
  localparam logic [7:0] OFS_ZONE_KP0 = 8'ha0;
  localparam int ZONES = 8;
  // ********************************************
  // ctrl and alarm fields, codes and modes
  // ********************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_IN_VALID = 2;
  localparam int CTRL_FFWD_EN = 3;
  localparam int CTRL_CAL_CUSTOM = 4;
  localparam int CTRL_ZONE_AUTO = 5;
  localparam int CTRL_TUNE_LSB = 6;
  localparam int CTRL_FOLLOW_OUT = 8;
  localparam int ALM_RELAY_LSB = 0;
  localparam int ALM_SOUND_LSB = 3;
  localparam int ALM_HAS_OUT = 6;
  localparam int ALM_MUTE = 7;
  localparam logic [15:0] ERR_LOCKED = 16'hff23;
  localparam logic [15:0] ERR_UNRECOG = 16'hff8f;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] UNITY_GAIN = 32'h0001_0000;
  localparam int FRAC = 16;
  typedef enum logic [2:0] {
    PRAC_OFF = 3'b001,
    PRAC_ON = 3'b010,
    PRAC_FOLLOW = 3'b100
  } prac_mode_e;
  localparam logic [1:0] MODE_OFF = 2'd0;
  localparam logic [1:0] MODE_ON = 2'd1;
  localparam logic [1:0] MODE_FOLLOW = 2'd2;
  localparam logic [1:0] TUNE_OFF = 2'd0;
  localparam logic [1:0] TUNE_STEP = 2'd2;
  localparam logic [1:0] TUNE_RELAY = 2'd3;
endpackage

// File: hw/prac_top.sv
// Contract
// - mute silences beep only, until alarm clears
// - alarm trip zeroes output, stops feedback
// - alarm clear restores output and prior feedback
// - alarm drives none or one of four relays
// - alarm beeps none or one to seven
// - calibration gain and offset after conversion
// - coefficient write locked unless custom calibration
// - locked error code minus 221, keep going
// - no input selected locks setpoint, ramp, pid, follow and zone writes
// - trapezoidal pid output law
// - follow mode locks ki kd, kp unrecognized
// - feedforward adds channel value when on
// - follow output is source minus zero times gain
// - zero and gain writes outside follow unrecognized
// - bad input selection clears input, disables feedback
// - feedback off holds output, on uses gains
// - relay tune needs output above half step
// - nonzero ramp rate ramps, zero jumps
// - target tracks sensor while feedback idle
// - target steps to setpoint then holds
// - eight zone bounds pick proportional gain by target temperature
`timescale 1ns/100ps
`default_nettype none
module prac_top #(
  parameter int W = 32,
  parameter int ZN = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sample_stb,
  input wire logic signed [31:0] sensor_raw,
  input wire logic signed [31:0] ffwd_value,
  input wire logic signed [31:0] follow_src,
  input wire logic alarm_trip,
  input wire logic tune_done,
  input wire logic signed [31:0] tune_step_y,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic signed [31:0] heater_out,
  output logic signed [31:0] sensor_temp,
  output logic [3:0] relay_out,
  output logic [2:0] beep_count,
  output logic beep_on
);
  // ********************************************
  // state
  // ********************************************
  logic [31:0] ctrl_r, setpt_r, ramp_r, kp_r, ki_r, kd_r, fgain_r, zero_r;
  logic [31:0] alarm_r, cgain_r, cofs_r, ca_r, cb_r, cc_r, outv_r;
  logic [15:0] err_r;
  logic signed [31:0] ramp_t_r, e_prev_r, integ_r, held_out_r;
  logic [31:0] tmin_r [ZN];
  logic [31:0] zkp_r [ZN];
  logic alarm_act_r, resume_fb_r, muted_r;
  prac_pkg::prac_mode_e mode_e;
  logic [1:0] mode;
  logic in_ok, fb_on;
  localparam int CTRL_MODE_LSB = prac_pkg::CTRL_MODE_LSB;
  assign mode = ctrl_r[CTRL_MODE_LSB +: 2];
  assign in_ok = ctrl_r[prac_pkg::CTRL_IN_VALID];
  assign fb_on = (mode == prac_pkg::MODE_ON) && !alarm_act_r;
  always_comb begin
    case (mode)
      prac_pkg::MODE_ON: mode_e = prac_pkg::PRAC_ON;
      prac_pkg::MODE_FOLLOW: mode_e = prac_pkg::PRAC_FOLLOW;
      default: mode_e = prac_pkg::PRAC_OFF;
    endcase
  end
  function automatic logic signed [31:0] fmul(input logic signed [31:0] a,
                                              input logic signed [31:0] b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return p[prac_pkg::FRAC +: 32];
  endfunction
  // ********************************************
  // axi write
  // ********************************************
  logic aw_hold, w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic do_wr;
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= prac_pkg::RESET_WORD;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = 2'b00;
  // ********************************************
  // register writes with lock checks
  // ********************************************
  logic [15:0] err_nxt;
  logic wr_ok;
  logic is_zone;
  logic [2:0] zidx;
  assign is_zone = aw_q[7];
  assign zidx = aw_q[4:2];
  always_comb begin
    err_nxt = prac_pkg::ERR_NONE;
    case (aw_q)
      prac_pkg::OFS_CTRL, prac_pkg::OFS_ALARM, prac_pkg::OFS_CAL_GAIN,
      prac_pkg::OFS_CAL_OFS, prac_pkg::OFS_OUT_VAL: err_nxt = prac_pkg::ERR_NONE;
      prac_pkg::OFS_COEF_A, prac_pkg::OFS_COEF_B, prac_pkg::OFS_COEF_C: begin
        if (!ctrl_r[prac_pkg::CTRL_CAL_CUSTOM]) err_nxt = prac_pkg::ERR_LOCKED;
      end
      prac_pkg::OFS_KP: begin
        if (!in_ok) err_nxt = prac_pkg::ERR_LOCKED;
        else if (mode == prac_pkg::MODE_FOLLOW) err_nxt = prac_pkg::ERR_UNRECOG;
      end
      prac_pkg::OFS_KI, prac_pkg::OFS_KD: begin
        if (!in_ok || mode == prac_pkg::MODE_FOLLOW) err_nxt = prac_pkg::ERR_LOCKED;
      end
      prac_pkg::OFS_FOLLOW_GAIN, prac_pkg::OFS_ZERO: begin
        if (!in_ok) err_nxt = prac_pkg::ERR_LOCKED;
        else if (mode != prac_pkg::MODE_FOLLOW) err_nxt = prac_pkg::ERR_UNRECOG;
      end
      prac_pkg::OFS_SETPT: begin
        if (!in_ok) err_nxt = prac_pkg::ERR_LOCKED;
        else if (mode == prac_pkg::MODE_FOLLOW) err_nxt = prac_pkg::ERR_UNRECOG;
      end
      prac_pkg::OFS_RAMP, prac_pkg::OFS_RAMP_T: begin
        if (!in_ok) err_nxt = prac_pkg::ERR_LOCKED;
      end
      default: begin
        if (is_zone && !in_ok) err_nxt = prac_pkg::ERR_LOCKED;
      end
    endcase
  end
  assign wr_ok = do_wr && (err_nxt == prac_pkg::ERR_NONE);
  logic [31:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = w_q;
    if (!w_q[prac_pkg::CTRL_IN_VALID])
      ctrl_nxt[CTRL_MODE_LSB +: 2] = prac_pkg::MODE_OFF;
    if (w_q[prac_pkg::CTRL_TUNE_LSB +: 2] == prac_pkg::TUNE_RELAY && heater_out <= (tune_step_y >>> 1))
      ctrl_nxt[prac_pkg::CTRL_TUNE_LSB +: 2] = prac_pkg::TUNE_OFF;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= prac_pkg::RESET_WORD;
      {setpt_r, ramp_r, kp_r, ki_r, kd_r, zero_r} <= {6{prac_pkg::RESET_WORD}};
      fgain_r <= prac_pkg::UNITY_GAIN;
      cgain_r <= prac_pkg::UNITY_GAIN;
      {alarm_r, cofs_r, ca_r, cb_r, cc_r, outv_r} <= {6{prac_pkg::RESET_WORD}};
      err_r <= prac_pkg::ERR_NONE;
    end else if (ce) begin
      if (do_wr) err_r <= err_nxt;
      if (tune_done) ctrl_r[CTRL_MODE_LSB +: 2] <= prac_pkg::MODE_OFF;
      if (tune_done) ctrl_r[prac_pkg::CTRL_TUNE_LSB +: 2] <= prac_pkg::TUNE_OFF;
      if (wr_ok) begin
        case (aw_q)
          prac_pkg::OFS_CTRL: ctrl_r <= ctrl_nxt;
          prac_pkg::OFS_SETPT: setpt_r <= w_q;
          prac_pkg::OFS_RAMP: ramp_r <= w_q;
          prac_pkg::OFS_KP: kp_r <= w_q;
          prac_pkg::OFS_KI: ki_r <= w_q;
          prac_pkg::OFS_KD: kd_r <= w_q;
          prac_pkg::OFS_FOLLOW_GAIN: fgain_r <= w_q;
          prac_pkg::OFS_ZERO: zero_r <= w_q;
          prac_pkg::OFS_ALARM: alarm_r <= w_q;
          prac_pkg::OFS_CAL_GAIN: cgain_r <= w_q;
          prac_pkg::OFS_CAL_OFS: cofs_r <= w_q;
          prac_pkg::OFS_COEF_A: ca_r <= w_q;
          prac_pkg::OFS_COEF_B: cb_r <= w_q;
          prac_pkg::OFS_COEF_C: cc_r <= w_q;
          prac_pkg::OFS_OUT_VAL: outv_r <= w_q;
          default: ;
        endcase
      end
    end
  end
  // ********************************************
  // zone table
  // ********************************************
  genvar g;
  generate
    for (g = 0; g < ZN; g++) begin : g_zone
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tmin_r[g] <= prac_pkg::RESET_WORD;
          zkp_r[g] <= prac_pkg::RESET_WORD;
        end else if (ce && wr_ok && is_zone && zidx == 3'(g)) begin
          if (aw_q[5]) zkp_r[g] <= w_q;
          else tmin_r[g] <= w_q;
        end
      end
    end
  endgenerate
  logic signed [31:0] kp_eff;
  logic [3:0] zone_sel;
  always_comb begin
    zone_sel = 4'hf;
    // highest bound at or below temperature wins; range ends at next bound
    for (int i = 0; i < ZN; i++) begin
      if ($signed(ramp_t_r) >= $signed(tmin_r[i]) &&
          (zone_sel == 4'hf || $signed(tmin_r[i]) >= $signed(tmin_r[zone_sel[2:0]])))
        zone_sel = 4'(i);
    end
    kp_eff = (ctrl_r[prac_pkg::CTRL_ZONE_AUTO] && zone_sel != 4'hf) ?
             zkp_r[zone_sel[2:0]] : kp_r;
  end
  // ********************************************
  // sample processing
  // ********************************************
  logic signed [31:0] temp_cal, err_now, pid_val, step;
  assign temp_cal = fmul(sensor_raw, cgain_r) + cofs_r;
  assign err_now = setpt_r - sensor_temp;
  assign step = (ramp_r == 32'h0) ? (setpt_r - ramp_t_r) : ramp_r;
  always_comb begin
    pid_val = fmul(kp_eff, err_now) + integ_r + fmul(ki_r, err_now + e_prev_r)
              + fmul(kd_r, err_now - e_prev_r);
    if (ctrl_r[prac_pkg::CTRL_FFWD_EN]) pid_val = pid_val + ffwd_value;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ramp_t_r <= 32'sh0;
      e_prev_r <= 32'sh0;
      integ_r <= 32'sh0;
      sensor_temp <= 32'sh0;
      heater_out <= 32'sh0;
      held_out_r <= 32'sh0;
      alarm_act_r <= 1'b0;
      resume_fb_r <= 1'b0;
    end else if (ce && sample_stb) begin
      sensor_temp <= temp_cal;
      if (alarm_trip && alarm_r[prac_pkg::ALM_HAS_OUT] && !alarm_act_r) begin
        alarm_act_r <= 1'b1;
        held_out_r <= heater_out;
        resume_fb_r <= (mode == prac_pkg::MODE_ON);
        heater_out <= 32'sh0;
      end else if (alarm_act_r) begin
        heater_out <= 32'sh0;
        if (!alarm_trip) begin
          alarm_act_r <= 1'b0;
          heater_out <= held_out_r;
        end
      end else if (fb_on && resume_fb_r | 1'b1) begin
        case (mode_e)
          prac_pkg::PRAC_ON: begin
            heater_out <= pid_val;
            integ_r <= integ_r + fmul(ki_r, err_now + e_prev_r);
            e_prev_r <= err_now;
          end
          default: ;
        endcase
      end else if (mode_e == prac_pkg::PRAC_FOLLOW) begin
        heater_out <= fmul(follow_src - zero_r, fgain_r);
      end
      if (!fb_on) ramp_t_r <= temp_cal;
      else if ($signed(setpt_r - ramp_t_r) > $signed(step) && ramp_r != 32'h0)
        ramp_t_r <= ramp_t_r + step;
      else if ($signed(ramp_t_r - setpt_r) > $signed(step) && ramp_r != 32'h0)
        ramp_t_r <= ramp_t_r - step;
      else ramp_t_r <= setpt_r;
    end else if (ce && wr_ok && aw_q == prac_pkg::OFS_OUT_VAL && mode == prac_pkg::MODE_OFF
                 && !alarm_act_r) begin
      heater_out <= w_q;
    end
  end
  // ********************************************
  // alarm relay and sound
  // ********************************************
  logic [2:0] rsel;
  assign rsel = alarm_r[prac_pkg::ALM_RELAY_LSB +: 3];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_out <= 4'h0;
      beep_count <= 3'h0;
      beep_on <= 1'b0;
      muted_r <= 1'b0;
    end else if (ce) begin
      for (int i = 0; i < 4; i++)
        relay_out[i] <= alarm_trip && rsel == 3'(i + 1);
      beep_count <= alarm_r[prac_pkg::ALM_SOUND_LSB +: 3];
      if (!alarm_trip) muted_r <= 1'b0;
      else if (alarm_r[prac_pkg::ALM_MUTE]) muted_r <= 1'b1;
      beep_on <= alarm_trip && !muted_r && !alarm_r[prac_pkg::ALM_MUTE]
                 && alarm_r[prac_pkg::ALM_SOUND_LSB +: 3] != 3'h0;
    end
  end
  // ********************************************
  // axi read
  // ********************************************
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      prac_pkg::OFS_CTRL: rd_mux = ctrl_r;
      prac_pkg::OFS_SETPT: rd_mux = setpt_r;
      prac_pkg::OFS_RAMP: rd_mux = ramp_r;
      prac_pkg::OFS_KP: rd_mux = kp_r;
      prac_pkg::OFS_KI: rd_mux = ki_r;
      prac_pkg::OFS_KD: rd_mux = kd_r;
      prac_pkg::OFS_FOLLOW_GAIN: rd_mux = fgain_r;
      prac_pkg::OFS_ZERO: rd_mux = zero_r;
      prac_pkg::OFS_ALARM: rd_mux = alarm_r;
      prac_pkg::OFS_CAL_GAIN: rd_mux = cgain_r;
      prac_pkg::OFS_CAL_OFS: rd_mux = cofs_r;
      prac_pkg::OFS_COEF_A: rd_mux = ca_r;
      prac_pkg::OFS_COEF_B: rd_mux = cb_r;
      prac_pkg::OFS_COEF_C: rd_mux = cc_r;
      prac_pkg::OFS_OUT_VAL: rd_mux = outv_r;
      prac_pkg::OFS_ERR: rd_mux = {16'h0, err_r};
      prac_pkg::OFS_RAMP_T: rd_mux = ramp_t_r;
      prac_pkg::OFS_STATUS: rd_mux = {27'h0, alarm_act_r, zone_sel};
      default: rd_mux = 32'h0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= prac_pkg::RESET_WORD;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ********************************************
  // checks
  // ********************************************
  sequence trip_s;
    sample_stb && ce && alarm_trip && alarm_r[prac_pkg::ALM_HAS_OUT] && !alarm_act_r;
  endsequence
  trip_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trip_s |=> heater_out == 0 && alarm_act_r) else $error("trip did not zero output");
  lock_err_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr && ce && !in_ok && aw_q == prac_pkg::OFS_KP |=> err_r == 16'hff23)
    else $error("locked code missing");
  ramp_track_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sample_stb && !fb_on |=> ramp_t_r == $past(temp_cal)) else $error("ramp not tracking");
  mute_beep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && alarm_r[prac_pkg::ALM_MUTE] |=> !beep_on) else $error("muted alarm beeped");
  relay_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $onehot0(relay_out)) else $error("more than one relay");
  coef_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && do_wr && aw_q == prac_pkg::OFS_COEF_A && !ctrl_r[4] |=> $stable(ca_r))
    else $error("coef written while locked");
  restore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && sample_stb && alarm_act_r && !alarm_trip |=> heater_out == $past(held_out_r))
    else $error("output not restored");
  tune_man_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && tune_done && !wr_ok |=> mode == prac_pkg::MODE_OFF) else $error("tune end mode");
endmodule
`default_nettype wire

// File: verification/prac_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module prac_sensor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_go,
  input wire logic signed [31:0] temp_set,
  input wire logic signed [31:0] trip_level,
  input wire logic tune_go,
  input wire logic signed [31:0] heater_out,
  input wire logic signed [31:0] tune_step_y,
  output logic sample_stb,
  output logic signed [31:0] sensor_raw,
  output logic alarm_trip,
  output logic tune_done
);
  // ********************************************
  // conversion strobe, alarm level, tuner
  // ********************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_stb <= 1'b0;
      sensor_raw <= 32'h0;
      alarm_trip <= 1'b0;
    end else begin
      sample_stb <= conv_go;
      if (conv_go) begin
        sensor_raw <= temp_set;
      end
      alarm_trip <= sensor_raw > trip_level;
    end
  end
  // relay tuner only finishes above half the step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tune_done <= 1'b0;
    end else begin
      tune_done <= tune_go && (heater_out > (tune_step_y >>> 1));
    end
  end
endmodule
`default_nettype wire

// File: verification/pid_ramp_alarm_controller_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pid_ramp_alarm_controller_tb;
  // ********************************************
  // stimulus and bus tasks
  // ********************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic conv_go = 1'b0;
  logic tune_go = 1'b0;
  logic ce = 1'b1;
  logic signed [31:0] temp_set = 32'h0;
  logic signed [31:0] trip_level = 32'h7fff_0000;
  logic signed [31:0] ffwd_value = 32'h0;
  logic signed [31:0] follow_src = 32'h0;
  logic signed [31:0] tune_step_y = 32'h0;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic sample_stb, alarm_trip, tune_done, beep_on;
  logic signed [31:0] sensor_raw, heater_out, sensor_temp;
  logic [3:0] relay_out;
  logic [2:0] beep_count;
  int n_mismatch = 0;
  int tests_run = 0;
  int k;
  localparam logic [7:0] LK_A [5] = '{prac_pkg::OFS_KP, prac_pkg::OFS_ZERO,
    prac_pkg::OFS_COEF_A, prac_pkg::OFS_FOLLOW_GAIN, prac_pkg::OFS_COEF_C};

  prac_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sample_stb(sample_stb),
    .sensor_raw(sensor_raw), .ffwd_value(ffwd_value), .follow_src(follow_src),
    .alarm_trip(alarm_trip), .tune_done(tune_done), .tune_step_y(tune_step_y),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .heater_out(heater_out), .sensor_temp(sensor_temp), .relay_out(relay_out),
    .beep_count(beep_count), .beep_on(beep_on));

  prac_sensor_model sensor (.aclk(aclk), .aresetn(aresetn), .conv_go(conv_go),
    .temp_set(temp_set), .trip_level(trip_level), .tune_go(tune_go),
    .heater_out(heater_out), .tune_step_y(tune_step_y), .sample_stb(sample_stb),
    .sensor_raw(sensor_raw), .alarm_trip(alarm_trip), .tune_done(tune_done));

  always #12.5 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
  endtask

  task automatic rdreg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    rdreg(a);
    chk(what, exp, rd);
  endtask

  task automatic echk(input logic [15:0] code);
    rdreg(prac_pkg::OFS_ERR);
    chk("err", {16'h0, code}, {16'h0, rd[15:0]});
  endtask

  // one converted sample, then time for the math to settle
  task automatic conv(input logic [31:0] t);
    temp_set <= t;
    conv_go <= 1'b1;
    @(posedge aclk);
    conv_go <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ********************************************
  // tests
  // ********************************************
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(prac_pkg::OFS_RAMP_T, 32'h0, "ramp_t");
    rchk(prac_pkg::OFS_KP, prac_pkg::RESET_WORD, "kp");
    chk("heater", 32'h0, heater_out);
    $display("test reset done");
    // locked and unrecognized writes alternate so each code is fresh
    for (k = 0; k < 5; k++) begin
      wr(prac_pkg::OFS_CTRL, (k == 0) ? 32'h0 : 32'h4);
      wr(LK_A[k], 32'h3_0000);
      echk(k[0] ? prac_pkg::ERR_UNRECOG : prac_pkg::ERR_LOCKED);
    end
    rchk(prac_pkg::OFS_KP, prac_pkg::RESET_WORD, "kp");
    wr(prac_pkg::OFS_CTRL, 32'h14);
    wr(prac_pkg::OFS_COEF_A, 32'h3_0000);
    rchk(prac_pkg::OFS_COEF_A, 32'h3_0000, "coef_a");
    $display("test locks done");
    wr(prac_pkg::OFS_CTRL, 32'h4);
    for (k = 0; k < 2; k++) begin
      wr(prac_pkg::OFS_CAL_GAIN, k ? 32'h1_0000 : 32'h2_0000);
      wr(prac_pkg::OFS_CAL_OFS, k ? 32'h1_0000 : 32'h0);
      conv(32'h3_0000);
      chk("sensor_temp", k ? 32'h4_0000 : 32'h6_0000, sensor_temp);
      rchk(prac_pkg::OFS_RAMP_T, k ? 32'h4_0000 : 32'h6_0000, "ramp_t");
    end
    wr(prac_pkg::OFS_CAL_OFS, 32'h0);
    $display("test calibration done");
    for (k = 1; k < 8; k++) begin
      wr(prac_pkg::OFS_TMIN0 + 8'(4 * k), (k == 2) ? 32'h2_0000 : 32'h7fff_0000);
    end
    conv(32'h3_0000);
    rdreg(prac_pkg::OFS_STATUS);
    chk("zone", 32'h2, 32'(rd[3:0]));
    conv(32'h1_0000);
    rdreg(prac_pkg::OFS_STATUS);
    chk("zone", 32'h0, 32'(rd[3:0]));
    ce <= 1'b0;
    conv(32'h3_0000);
    chk("sensor_temp", 32'h1_0000, sensor_temp);
    ce <= 1'b1;
    $display("test zones done");
    // input, follow mode
    wr(prac_pkg::OFS_CTRL, 32'h6);
    wr(prac_pkg::OFS_KI, 32'h0);
    echk(prac_pkg::ERR_LOCKED);
    wr(prac_pkg::OFS_KP, 32'h0);
    echk(prac_pkg::ERR_UNRECOG);
    wr(prac_pkg::OFS_ZERO, 32'h1_0000);
    wr(prac_pkg::OFS_FOLLOW_GAIN, 32'h2_0000);
    follow_src <= 32'h5_0000;
    conv(32'h3_0000);
    chk("heater", 32'h8_0000, heater_out);
    $display("test follow done");
    wr(prac_pkg::OFS_CTRL, 32'h4);
    wr(prac_pkg::OFS_KI, 32'h0);
    wr(prac_pkg::OFS_KD, 32'h0);
    wr(prac_pkg::OFS_KP, 32'h2_0000);
    wr(prac_pkg::OFS_RAMP, 32'h1_0000);
    wr(prac_pkg::OFS_SETPT, 32'h5_0000);
    conv(32'h2_0000);
    rchk(prac_pkg::OFS_RAMP_T, 32'h2_0000, "ramp_t");
    wr(prac_pkg::OFS_CTRL, 32'h5);
    for (k = 1; k < 5; k++) begin
      conv(32'h2_0000);
      rchk(prac_pkg::OFS_RAMP_T, (k < 3) ? 32'(k + 2) << 16 : 32'h5_0000, "ramp_t");
    end
    chk("heater", 32'h6_0000, heater_out);
    wr(prac_pkg::OFS_RAMP, 32'h0);
    wr(prac_pkg::OFS_SETPT, 32'h7_0000);
    conv(32'h2_0000);
    rchk(prac_pkg::OFS_RAMP_T, 32'h7_0000, "ramp_t");
    conv(32'h2_0000);
    chk("heater", 32'ha_0000, heater_out);
    ffwd_value <= 32'h1_0000;
    wr(prac_pkg::OFS_CTRL, 32'hd);
    conv(32'h2_0000);
    conv(32'h2_0000);
    chk("heater", 32'hb_0000, heater_out);
    wr(prac_pkg::OFS_CTRL, 32'hc);
    conv(32'h3_0000);
    chk("heater", 32'hb_0000, heater_out);
    rchk(prac_pkg::OFS_RAMP_T, 32'h3_0000, "ramp_t");
    $display("test feedback done");
    wr(prac_pkg::OFS_ALARM, 32'h1 << prac_pkg::ALM_HAS_OUT);
    wr(prac_pkg::OFS_CTRL, 32'hd);
    trip_level <= 32'h4_0000;
    conv(32'h3_0000);
    conv(32'h3_0000);
    chk("heater", 32'h9_0000, heater_out);
    conv(32'h5_0000);
    conv(32'h5_0000);
    chk("heater", 32'h0, heater_out);
    conv(32'h3_0000);
    conv(32'h3_0000);
    chk("heater", 32'h9_0000, heater_out);
    $display("test shutoff done");
    for (k = 0; k < 5; k++) begin
      wr(prac_pkg::OFS_ALARM, 32'(k) | (32'(k) << prac_pkg::ALM_SOUND_LSB));
      conv(32'h5_0000);
      conv(32'h5_0000);
      chk("relay", (k == 0) ? 32'h0 : 32'h1 << (k - 1), 32'(relay_out));
      chk("beep_count", 32'(k), 32'(beep_count));
      chk("beep_on", 32'(k != 0), 32'(beep_on));
      wr(prac_pkg::OFS_ALARM, 32'(k) | (32'(k) << prac_pkg::ALM_SOUND_LSB) | 32'h80);
      conv(32'h5_0000);
      chk("beep_on", 32'h0, 32'(beep_on));
      chk("relay", (k == 0) ? 32'h0 : 32'h1 << (k - 1), 32'(relay_out));
      wr(prac_pkg::OFS_ALARM, 32'(k) | (32'(k) << prac_pkg::ALM_SOUND_LSB));
      conv(32'h5_0000);
      chk("beep_on", 32'h0, 32'(beep_on));
      conv(32'h3_0000);
      conv(32'h3_0000);
      chk("relay", 32'h0, 32'(relay_out));
    end
    $display("test relays done");
    tune_step_y <= 32'h2_0000;
    tune_go <= 1'b1;
    @(posedge aclk);
    tune_go <= 1'b0;
    repeat (4) @(posedge aclk);
    rdreg(prac_pkg::OFS_CTRL);
    chk("mode", 32'(prac_pkg::MODE_OFF), 32'(rd[1:0]));
    wr(prac_pkg::OFS_CTRL, 32'h5);
    wr(prac_pkg::OFS_CTRL, 32'h1);
    rdreg(prac_pkg::OFS_CTRL);
    chk("ctrl", 32'h0, 32'(rd[2:0]));
    $display("test tune and input done");
    end_of_test();
  end
endmodule
`default_nettype wire
